// ===== pkg/wkt_pkg.sv
`default_nettype none
package wkt_pkg;
    // Printed offsets are not all multiples of four, so they are register indices.
    localparam logic [7:0] IDX_CONTROL = 8'h23;
    localparam logic [7:0] IDX_RELOAD_HIGH = 8'h24;
    localparam logic [7:0] IDX_RELOAD_LOW = 8'h25;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'h26;
    localparam logic [7:0] IDX_COUNT_LOW = 8'h27;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h28;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h29;
    localparam logic [7:0] IDX_POWER_STATUS = 8'h2A;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 12;

    localparam int CTL_RUNNING = 7;
    localparam int CTL_RUN_CHANGE = 6;
    localparam int CTL_TRIM = 5;
    localparam int CTL_CARD = 4;
    localparam int CTL_RELOAD = 3;
    localparam int CTL_WAKE = 2;
    localparam int CTL_DIV_HI = 1;

    localparam logic [1:0] DIV_NONE = 2'h0;
    localparam logic [1:0] DIV_8 = 2'h1;
    localparam logic [1:0] DIV_16 = 2'h2;
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV16_LAST = 5'h0F;
    localparam logic [4:0] DIV32_LAST = 5'h1F;

    // Interrupt status bits: underflow, card found, no card.
    localparam int IRQ_W = 3;
    localparam int IRQ_UNDERFLOW = 0;
    localparam int IRQ_CARD = 1;
    localparam int IRQ_NOCARD = 2;

    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : wkt_pkg
`default_nettype wire

// ===== hdl/wkt_wakeup_timer.sv
// Notes on behaviour
// - Control bit 7 shows whether the timer is counting; readable any time.
// - Software changes running only by a control write that also sets bit 6.
// - Bit 5 set: each underflow launches oscillator trimming.
// - Bit 4 set: underflow starts card detection; found card raises interrupt.
// - No card found: return to power-down if return is enabled.
// - With card detection, reload and continue at underflow with no gap.
// - The field-on probe interval is timed by the third timer.
// - Bit 3 set reloads at zero and continues; clear stops at zero unless bit 4 is set.
// - Every underflow sets the wake-up interrupt flag.
// - Bit 2 set wakes the device from power-down on underflow.
// - Bits 1:0 pick oscillator tick undivided, /8, /16 or /32.
// - Each start loads the counter from the 16-bit reload value.
// - Reload writes do not disturb a running count; next start applies.
// - Live counter readable as read-only high and low bytes.
// - Control 23h, reload 24h/25h, count 26h/27h, eight bits each.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module wkt_wakeup_timer
    import wkt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_freq_oscillator,
    input wire logic card_detect_done,
    input wire logic card_detect_found,
    output logic wakeup_underflow_irq,
    output logic osc_trim_start,
    output logic card_detect_start,
    output logic wake_request,
    output logic power_down_request,
    output logic irq
);
    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic osc_s1;
        logic osc_s2;
        logic osc_prev;
        logic done_s1;
        logic done_s2;
        logic found_s1;
        logic found_s2;
        logic done_prev;
        logic [4:0] div_cnt;
        logic wakeup_running_flag;
        logic auto_osc_trim_enable;
        logic auto_card_detect_enable;
        logic auto_reload_enable;
        logic auto_wake_enable;
        logic [1:0] tick_divider_select;
        logic [7:0] reload_high;
        logic [7:0] reload_low;
        logic [15:0] count;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic card_busy;
        logic osc_trim_start;
        logic card_detect_start;
        logic wake_request;
        logic power_down_request;
        logic irq;
        logic [31:0] prdata;
        logic pready;
    } wkt_state_t;

    wkt_state_t st_r;
    wkt_state_t st_nxt;

    logic [7:0] reg_idx;
    logic osc_rise;
    logic tick;
    logic underflow;
    logic wr_en;
    logic rd_en;
    logic [IRQ_W-1:0] irq_set;
    logic [4:0] div_last;
    logic [15:0] reload_value;

    assign reg_idx = paddr[ADDR_LSB +: 8];
    // Writes land at the access edge, when pready is seen high. Reads are
    // taken in the setup cycle so that the registered data stands through
    // the access cycle; the master takes it at the edge that ends the access.
    assign wr_en = psel && penable && pwrite && st_r.pready;
    assign rd_en = psel && !penable && !pwrite;
    assign reload_value = {st_r.reload_high, st_r.reload_low};

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Oscillator and detector status arrive asynchronously.
        st_nxt.osc_s1 = low_freq_oscillator;
        st_nxt.osc_s2 = st_r.osc_s1;
        st_nxt.osc_prev = st_r.osc_s2;
        st_nxt.done_s1 = card_detect_done;
        st_nxt.done_s2 = st_r.done_s1;
        st_nxt.found_s1 = card_detect_found;
        st_nxt.found_s2 = st_r.found_s1;
        st_nxt.done_prev = st_r.done_s2;
        osc_rise = st_r.osc_s2 && !st_r.osc_prev;

        unique case (st_r.tick_divider_select)
            DIV_NONE: div_last = 5'h00;
            DIV_8: div_last = DIV8_LAST;
            DIV_16: div_last = DIV16_LAST;
            default: div_last = DIV32_LAST;
        endcase
        // A count at or above the last value wraps at once, so a divider change
        // made while counting never strands the prescaler.
        tick = 1'b0;
        if (osc_rise) begin
            if (st_r.div_cnt >= div_last) begin
                st_nxt.div_cnt = 5'h00;
                tick = 1'b1;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt + 5'h01;
            end
        end

        // Counting; the step from zero is the underflow.
        underflow = 1'b0;
        if (st_r.wakeup_running_flag && tick) begin
            if (st_r.count == COUNT_ZERO) begin
                underflow = 1'b1;
                // Card detection forces continuous reload with no gap.
                if (st_r.auto_reload_enable || st_r.auto_card_detect_enable) begin
                    st_nxt.count = reload_value;
                end else begin
                    st_nxt.wakeup_running_flag = 1'b0;
                end
            end else begin
                st_nxt.count = st_r.count - COUNT_ONE;
            end
        end

        st_nxt.osc_trim_start = underflow && st_r.auto_osc_trim_enable;
        // The probe interval itself is timed by the third timer outside.
        st_nxt.card_detect_start = underflow && st_r.auto_card_detect_enable;
        st_nxt.wake_request = underflow && st_r.auto_wake_enable;
        st_nxt.power_down_request = 1'b0;
        irq_set = '0;
        irq_set[IRQ_UNDERFLOW] = underflow;
        if (st_r.card_busy && st_r.done_s2 && !st_r.done_prev) begin
            st_nxt.card_busy = 1'b0;
            irq_set[IRQ_CARD] = st_r.found_s2;
            irq_set[IRQ_NOCARD] = !st_r.found_s2;
            // Return to power-down only when auto-wake is enabled.
            st_nxt.power_down_request = !st_r.found_s2 && st_r.auto_wake_enable;
        end
        // A round that starts as the previous one ends must not be lost, so the
        // start is applied after the end.
        if (underflow && st_r.auto_card_detect_enable) begin
            st_nxt.card_busy = 1'b1;
        end

        // Register writes.
        if (wr_en && pstrb[0]) begin
            unique case (reg_idx)
                IDX_CONTROL: begin
                    st_nxt.auto_osc_trim_enable = pwdata[CTL_TRIM];
                    st_nxt.auto_card_detect_enable = pwdata[CTL_CARD];
                    st_nxt.auto_reload_enable = pwdata[CTL_RELOAD];
                    st_nxt.auto_wake_enable = pwdata[CTL_WAKE];
                    st_nxt.tick_divider_select = pwdata[CTL_DIV_HI:0];
                    if (pwdata[CTL_RUN_CHANGE]) begin
                        st_nxt.wakeup_running_flag = pwdata[CTL_RUNNING];
                        if (pwdata[CTL_RUNNING]) begin
                            st_nxt.count = reload_value;
                            st_nxt.div_cnt = 5'h00;
                        end
                    end
                end
                IDX_RELOAD_HIGH: st_nxt.reload_high = pwdata[7:0];
                IDX_RELOAD_LOW: st_nxt.reload_low = pwdata[7:0];
                IDX_IRQ_MASK: st_nxt.irq_mask = pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // Read data and read-to-clear act at the setup edge, together, so a status
        // bit raised between setup and access is kept for the next read. A set in
        // the same cycle as the clear wins.
        st_nxt.prdata = RDATA_ZERO;
        st_nxt.pready = psel && !penable;
        if (rd_en) begin
            unique case (reg_idx)
                IDX_CONTROL: st_nxt.prdata[7:0] = {st_r.wakeup_running_flag, 1'b0,
                    st_r.auto_osc_trim_enable, st_r.auto_card_detect_enable,
                    st_r.auto_reload_enable, st_r.auto_wake_enable,
                    st_r.tick_divider_select};
                IDX_RELOAD_HIGH: st_nxt.prdata[7:0] = st_r.reload_high;
                IDX_RELOAD_LOW: st_nxt.prdata[7:0] = st_r.reload_low;
                IDX_COUNT_HIGH: st_nxt.prdata[7:0] = st_r.count[15:8];
                IDX_COUNT_LOW: st_nxt.prdata[7:0] = st_r.count[7:0];
                IDX_IRQ_STATUS: begin
                    st_nxt.prdata[IRQ_W-1:0] = st_r.irq_status;
                    st_nxt.irq_status = '0;
                end
                IDX_IRQ_MASK: st_nxt.prdata[IRQ_W-1:0] = st_r.irq_mask;
                IDX_POWER_STATUS: st_nxt.prdata[0] = st_r.card_busy;
                default: ;
            endcase
        end
        st_nxt.irq_status = st_nxt.irq_status | irq_set;
        // The new mask counts at once, so a masking write silences irq at once.
        st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = 1'b0;
    assign wakeup_underflow_irq = st_r.irq_status[IRQ_UNDERFLOW];
    assign osc_trim_start = st_r.osc_trim_start;
    assign card_detect_start = st_r.card_detect_start;
    assign wake_request = st_r.wake_request;
    assign power_down_request = st_r.power_down_request;
    assign irq = st_r.irq;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_run_change_gate: assert property (
        (st_r.wakeup_running_flag != $past(st_r.wakeup_running_flag)) && $past(wr_en)
        && $past(reg_idx) == IDX_CONTROL |-> $past(pwdata[CTL_RUN_CHANGE]) || $past(tick))
        else $error("running flag changed by a write without the change strobe");
    a_start_loads_reload: assert property (
        wr_en && pstrb[0] && reg_idx == IDX_CONTROL && pwdata[CTL_RUN_CHANGE]
        && pwdata[CTL_RUNNING] |=> st_r.count == $past(reload_value))
        else $error("start did not load the reload value");
    a_underflow_flag: assert property (
        underflow |=> st_r.irq_status[IRQ_UNDERFLOW])
        else $error("underflow did not set the interrupt flag");
    a_oneshot_stops: assert property (
        underflow && !st_r.auto_reload_enable && !st_r.auto_card_detect_enable
        && !wr_en |=> !st_r.wakeup_running_flag)
        else $error("one-shot timer kept running after underflow");
    a_card_no_gap: assert property (
        underflow && st_r.auto_card_detect_enable && !wr_en
        |=> st_r.wakeup_running_flag && st_r.count == $past(reload_value))
        else $error("card detection mode left a gap after underflow");
    a_trim_launch: assert property (
        underflow |=> osc_trim_start == $past(st_r.auto_osc_trim_enable))
        else $error("trim launch does not follow underflow");
    a_wake_on_under: assert property (
        wake_request |-> $past(underflow) && $past(st_r.auto_wake_enable))
        else $error("wake request without enabled underflow");
    a_count_steps: assert property (
        st_r.wakeup_running_flag && tick && st_r.count != COUNT_ZERO && !wr_en
        |=> st_r.count == $past(st_r.count) - COUNT_ONE)
        else $error("counter did not step down by one");
    a_reload_no_disturb: assert property (
        wr_en && (reg_idx == IDX_RELOAD_LOW) && !(st_r.wakeup_running_flag && tick)
        |=> st_r.count == $past(st_r.count))
        else $error("reload write disturbed the count");

    // -------------------------------------------------------------------
    // Bus checks
    // -------------------------------------------------------------------
    a_pready_access: assert property (
        psel && !penable |=> pready)
        else $error("access cycle did not answer ready");
    a_pready_idle: assert property (
        !(psel && !penable) |=> !pready)
        else $error("ready raised outside an access cycle");
    a_read_idle_zero: assert property (
        !rd_en |=> prdata == RDATA_ZERO)
        else $error("read data not zero outside a read");
    a_running_readout: assert property (
        rd_en && reg_idx == IDX_CONTROL
        |=> prdata[CTL_RUNNING] == $past(st_r.wakeup_running_flag)
        && !prdata[CTL_RUN_CHANGE])
        else $error("control read does not show the running flag");
    a_count_high_live: assert property (
        rd_en && reg_idx == IDX_COUNT_HIGH |=> prdata[7:0] == $past(st_r.count[15:8]))
        else $error("count high read is not the live count");
    a_count_low_live: assert property (
        rd_en && reg_idx == IDX_COUNT_LOW |=> prdata[7:0] == $past(st_r.count[7:0]))
        else $error("count low read is not the live count");
    a_stop_strobe: assert property (
        wr_en && pstrb[0] && reg_idx == IDX_CONTROL && pwdata[CTL_RUN_CHANGE]
        && !pwdata[CTL_RUNNING] |=> !st_r.wakeup_running_flag)
        else $error("stop with the change strobe left the timer running");
    a_no_strobe_keeps: assert property (
        wr_en && pstrb[0] && reg_idx == IDX_CONTROL && !pwdata[CTL_RUN_CHANGE]
        && !underflow |=> st_r.wakeup_running_flag == $past(st_r.wakeup_running_flag))
        else $error("write without the change strobe moved the running flag");
    a_start_div_clear: assert property (
        wr_en && pstrb[0] && reg_idx == IDX_CONTROL && pwdata[CTL_RUN_CHANGE]
        && pwdata[CTL_RUNNING] |=> st_r.div_cnt == '0)
        else $error("start did not restart the divider");
    a_reload_high_keep: assert property (
        wr_en && (reg_idx == IDX_RELOAD_HIGH) && !(st_r.wakeup_running_flag && tick)
        |=> st_r.count == $past(st_r.count))
        else $error("reload high write disturbed the count");
    a_stopped_count_held: assert property (
        !st_r.wakeup_running_flag && !wr_en |=> st_r.count == $past(st_r.count))
        else $error("stopped counter moved");

    // -------------------------------------------------------------------
    // Detection checks
    // -------------------------------------------------------------------
    // A round opens on a card-mode underflow and closes on the synchronised
    // rising edge of done; the found level is read at that closing edge.
    sequence s_detect_done;
        st_r.card_busy && st_r.done_s2 && !st_r.done_prev;
    endsequence

    sequence s_card_underflow;
        underflow && st_r.auto_card_detect_enable;
    endsequence

    // Ticks come at least two cycles apart, so the start pulse always falls.
    a_card_start: assert property (
        s_card_underflow |=> card_detect_start ##1 !card_detect_start)
        else $error("card detection start is not a single pulse after underflow");
    a_detect_busy: assert property (
        s_card_underflow |=> st_r.card_busy)
        else $error("card detection round not marked busy");
    a_found_irq: assert property (
        s_detect_done ##0 st_r.found_s2 |=> st_r.irq_status[IRQ_CARD])
        else $error("found card did not raise its status bit");
    a_found_stays: assert property (
        s_detect_done ##0 st_r.found_s2 |=> !power_down_request)
        else $error("found card still asked for power-down");
    a_nocard_pdown: assert property (
        s_detect_done ##0 !st_r.found_s2
        |=> power_down_request == $past(st_r.auto_wake_enable))
        else $error("no card did not follow the return setting");
    a_pdown_cause: assert property (
        power_down_request
        |-> $past(st_r.card_busy && st_r.done_s2 && !st_r.done_prev && !st_r.found_s2))
        else $error("power-down request without a finished empty round");
    a_irq_level: assert property (
        irq == |(st_r.irq_status & st_r.irq_mask))
        else $error("interrupt output does not follow status and mask");
    a_wake_pulse: assert property (
        underflow |=> wake_request == $past(st_r.auto_wake_enable))
        else $error("wake request does not follow underflow");
    a_trim_cause: assert property (
        osc_trim_start |-> $past(underflow))
        else $error("trim launch without underflow");
    a_card_cause: assert property (
        card_detect_start |-> $past(underflow))
        else $error("card detection start without underflow");
endmodule : wkt_wakeup_timer
`default_nettype wire

// ===== tb/wakeup_timer_low_power_card_detection_test.sv
`timescale 1ns/1ps
`default_nettype none
module wakeup_timer_low_power_card_detection_test;
    import wkt_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, low_freq_oscillator = 1'h0;
    logic card_detect_done = 1'h0;
    logic card_detect_found = 1'h0;
    logic wakeup_underflow_irq, osc_trim_start, card_detect_start;
    logic wake_request, power_down_request, irq;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 81;
    int cyc = 0;
    int lfo_phase = 0;
    int lfo_edges = 0;
    int n_trim = 0, n_card = 0, n_wake = 0, n_pdown = 0;
    logic [7:0] rd;

    wkt_wakeup_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .low_freq_oscillator(low_freq_oscillator),
        .card_detect_done(card_detect_done), .card_detect_found(card_detect_found),
        .wakeup_underflow_irq(wakeup_underflow_irq), .osc_trim_start(osc_trim_start),
        .card_detect_start(card_detect_start), .wake_request(wake_request),
        .power_down_request(power_down_request), .irq(irq));

    always #12.5 pclk = ~pclk;

    // ----------------------------------------
    // Oscillator, pulse monitor and timeout
    // ----------------------------------------
    // The oscillator runs at one eighth of pclk so that its synchroniser latency stays
    // below one oscillator period and tick counts can be bounded tightly.
    always @(posedge pclk) begin
        lfo_phase <= (lfo_phase + 1) % 8;
        low_freq_oscillator <= (lfo_phase < 4);
        if (lfo_phase == 0) begin
            lfo_edges <= lfo_edges + 1;
        end
        n_trim <= n_trim + int'(osc_trim_start === 1'h1);
        n_card <= n_card + int'(card_detect_start === 1'h1);
        n_wake <= n_wake + int'(wake_request === 1'h1);
        n_pdown <= n_pdown + int'(power_down_request === 1'h1);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            close_out();
        end
    end

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic check_in(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check_in

    // The request stands until pready is seen high at a rising edge; read data is
    // taken at that same edge, and one idle cycle follows before the next setup.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= ADDR_W'({idx, 2'h0});
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata[7:0];
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb

    task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        apb(1'h0, idx, 8'h00);
        check(what, exp, rd);
    endtask : rchk

    task automatic wait_uf;
        int k;
        k = 0;
        while (wakeup_underflow_irq !== 1'h1 && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        check("underflow flag", 8'h01, {7'h00, wakeup_underflow_irq});
    endtask : wait_uf

    // A round ends only after the block has opened one with its start pulse.
    task automatic detect(input logic hit);
        while (card_detect_start !== 1'h1) @(posedge pclk);
        card_detect_found <= hit;
        card_detect_done <= 1'h1;
        repeat (4) @(posedge pclk);
        card_detect_done <= 1'h0;
        repeat (4) @(posedge pclk);
    endtask : detect

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin : main
        logic [15:0] rl;
        int e0, dv, p0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rchk("control reset", IDX_CONTROL, 8'h00);
        rchk("reload high reset", IDX_RELOAD_HIGH, 8'h00);
        rchk("count low reset", IDX_COUNT_LOW, 8'h00);
        rchk("unmapped read", 8'h30, 8'h00);
        pstrb <= 4'h0;
        apb(1'h1, IDX_RELOAD_LOW, 8'h5A);
        pstrb <= 4'hF;
        rchk("masked lane write", IDX_RELOAD_LOW, 8'h00);
        apb(1'h1, IDX_CONTROL, 8'h80);
        rchk("start without strobe", IDX_CONTROL, 8'h00);
        for (int d = 0; d < 4; d++) begin
            rl = 16'(($random(seed) & 3) + 1);
            dv = (d == 0) ? 1 : (4 << d);
            apb(1'h1, IDX_RELOAD_HIGH, 8'h00);
            apb(1'h1, IDX_RELOAD_LOW, rl[7:0]);
            rchk("reload low", IDX_RELOAD_LOW, rl[7:0]);
            apb(1'h1, IDX_CONTROL, 8'hC0 | 8'(d));
            e0 = lfo_edges;
            wait_uf();
            check_in("ticks to underflow", (rl + 1) * dv - 1, (rl + 1) * dv + 1,
                lfo_edges - e0);
            rchk("stopped at zero", IDX_CONTROL, 8'(d));
            rchk("count at zero", IDX_COUNT_LOW, 8'h00);
            rchk("status read", IDX_IRQ_STATUS, 8'h01);
            check("flag cleared", 8'h00, {7'h00, wakeup_underflow_irq});
        end
        apb(1'h1, IDX_IRQ_MASK, 8'h01);
        apb(1'h1, IDX_RELOAD_LOW, 8'h01);
        apb(1'h1, IDX_CONTROL, 8'hEC);
        wait_uf();
        check("irq unmasked", 8'h01, {7'h00, irq});
        repeat (3) @(posedge pclk);
        rchk("still running", IDX_CONTROL, 8'hAC);
        check_in("trim pulses", 1, 1000, n_trim);
        check_in("wake pulses", n_trim - 1, n_trim + 1, n_wake);
        apb(1'h1, IDX_IRQ_MASK, 8'h00);
        apb(1'h0, IDX_IRQ_STATUS, 8'h00);
        wait_uf();
        check("irq masked", 8'h00, {7'h00, irq});
        apb(1'h1, IDX_CONTROL, 8'h40);
        rchk("stopped", IDX_CONTROL, 8'h00);
        apb(1'h0, IDX_IRQ_STATUS, 8'h00);
        p0 = n_card;
        apb(1'h1, IDX_CONTROL, 8'hD4);
        wait_uf();
        repeat (3) @(posedge pclk);
        check_in("detect start", p0 + 1, p0 + 3, n_card);
        p0 = n_pdown;
        detect(1'h0);
        check_in("power down", p0 + 1, p0 + 1, n_pdown);
        rchk("no gap restart", IDX_CONTROL, 8'h94);
        apb(1'h0, IDX_IRQ_STATUS, 8'h00);
        check("no card status", 8'h01, {7'h00, rd[IRQ_NOCARD]});
        p0 = n_pdown;
        detect(1'h1);
        check_in("no power down", p0, p0, n_pdown);
        apb(1'h0, IDX_IRQ_STATUS, 8'h00);
        check("card status", 8'h01, {7'h00, rd[IRQ_CARD]});
        apb(1'h1, IDX_CONTROL, 8'h40);
        apb(1'h1, IDX_RELOAD_HIGH, 8'h03);
        apb(1'h1, IDX_CONTROL, 8'hC0);
        apb(1'h1, IDX_RELOAD_HIGH, 8'h00);
        apb(1'h1, IDX_CONTROL, 8'h00);
        rchk("stop without strobe", IDX_CONTROL, 8'h80);
        apb(1'h0, IDX_COUNT_HIGH, 8'h00);
        check_in("count high kept", 2, 3, int'(rd));
        apb(1'h1, IDX_CONTROL, 8'h40);
        rchk("final stop", IDX_CONTROL, 8'h00);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rchk("control after reset", IDX_CONTROL, 8'h00);
        rchk("count high after reset", IDX_COUNT_HIGH, 8'h00);
        close_out();
    end
endmodule : wakeup_timer_low_power_card_detection_test
`default_nettype wire
